// ### core/swap_tblrd_pkg.sv
// package for the nibble swap and table read execution block
// assumes a core clock of 200 MHz and four phase instruction cycles
`default_nettype none
package swap_tblrd_pkg;
	// *************************
	// opcode fields
	// *************************
	localparam logic [6:0] NIBBLE_SWAP_TOP = 7'h0e; // 0001 110
	localparam logic [5:0] TABLE_READ_TOP = 6'h2a; // 1010 10
	localparam int TABLE_SEL_BIT = 9;
	localparam int TABLE_INC_BIT = 8;
	localparam int SWAP_DEST_BIT = 8;
	// *************************
	// reset values and timing
	// *************************
	localparam logic [15:0] POINTER_RESET = 16'h0000;
	localparam logic [15:0] LATCH_RESET = 16'h0000;
	localparam logic [7:0] PC_LOW_ADDR = 8'h02;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam int CYCLES_NORMAL = 2;
	localparam int CYCLES_PC_LOW = 3;
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage
`default_nettype wire

// ### core/quarter_counter.sv
// free running four phase counter for the instruction cycle
// assumes one clock per quarter of an instruction cycle
`timescale 1ns/10ps
`default_nettype none
module quarter_counter
(
	input wire logic clk,
	input wire logic reset_n,
	output logic [1:0] phase
);
	// *************************
	// phase counter
	// *************************
	typedef struct packed {logic [1:0] ph;} qstate_t;
	qstate_t state;
	qstate_t next_state;
	// advance one quarter per clock
	always_comb
	begin
		next_state = state;
		next_state.ph = state.ph + 2'h1;
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end
	assign phase = state.ph;
endmodule
`default_nettype wire

// ### core/swap_tblrd_exec.sv
// execution of nibble swap and table read instructions
// assumes instruction is presented at Q1 with instValid and held one cycle;
// register file data for the source is given on srcData
// How it works
// - swap puts source low nibble high and source high nibble low
// - table read opcode is 101010 then t, i and 8 bit address
// - any address 0..255 and any t and i values are taken
// - t one moves latch high byte, zero moves latch low byte
// - i one increments the pointer after the read, else unchanged
// - table read is two cycles, three when destination is program counter low
// - second cycle puts pointer on address bus, output enable low in Q4
`timescale 1ns/10ps
`default_nettype none
module swap_tblrd_exec
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic instValid,
	input wire logic [15:0] instWord,
	input wire logic [7:0] srcData,
	input wire logic [15:0] memData,
	output logic [7:0] regWrData,
	output logic [7:0] regWrAddr,
	output logic regWrEn,
	output logic workWrEn,
	output logic [15:0] memAddr,
	output logic memOe_n,
	output logic busy,
	output logic [15:0] tablePointer,
	output logic [15:0] tableLatch
);
	// *************************
	// state
	// *************************
	// a read spends its first cycle on the byte move and its second on the fetch
	typedef enum logic [1:0] {IDLE, RD_FIRST, RD_FETCH, RD_EXTRA} mode_t;
	typedef struct packed {
		mode_t mode;
		logic inc;
		logic [15:0] ptr;
		logic [15:0] lat;
		logic [7:0] wd;
		logic [7:0] wa;
		logic we;
		logic wwe;
		logic [15:0] ma;
		logic oe_n;
		logic bsy;
	} st_t;
	st_t s;
	st_t next_s;
	logic [1:0] phase;
	logic isSwap;
	logic isRead;

	quarter_counter u_phase
	(
		.clk(clk),
		.reset_n(reset_n),
		.phase(phase)
	);

	// decode is reused by logic and by checks
	function automatic logic is_read(input logic [15:0] w);
		is_read = (w[15:10] == swap_tblrd_pkg::TABLE_READ_TOP);
	endfunction
	function automatic logic is_swap(input logic [15:0] w);
		is_swap = (w[15:9] == swap_tblrd_pkg::NIBBLE_SWAP_TOP);
	endfunction
	// only an idle block takes a word, so anything offered during a read is dropped
	assign isSwap = s.mode == IDLE && instValid && phase == 2'(swap_tblrd_pkg::PH_Q1) && is_swap(instWord);
	assign isRead = s.mode == IDLE && instValid && phase == 2'(swap_tblrd_pkg::PH_Q1) && is_read(instWord);

	// *************************
	// next state
	// *************************
	// writes are one clock strobes in Q2; the bus stays quiet outside a read
	always_comb
	begin
		next_s = s;
		next_s.we = 1'b0;
		next_s.wwe = 1'b0;
		next_s.oe_n = 1'b1;
		unique case (s.mode)
			IDLE:
			begin
				if (isSwap)
				begin
					next_s.wd = {srcData[3:0], srcData[7:4]};
					next_s.wa = instWord[7:0];
					next_s.we = instWord[swap_tblrd_pkg::SWAP_DEST_BIT];
					next_s.wwe = !instWord[swap_tblrd_pkg::SWAP_DEST_BIT];
				end
				else if (isRead)
				begin
					// any of 256 addresses and both bit values accepted
					next_s.wa = instWord[7:0];
					next_s.wd = instWord[swap_tblrd_pkg::TABLE_SEL_BIT] ? s.lat[15:8] : s.lat[7:0];
					next_s.we = 1'b1;
					next_s.inc = instWord[swap_tblrd_pkg::TABLE_INC_BIT];
					next_s.mode = RD_FIRST;
				end
			end
			// first cycle: the byte move is out, the memory bus waits for the next cycle
			RD_FIRST:
			begin
				if (phase == swap_tblrd_pkg::PHASE_LAST)
					next_s.mode = RD_FETCH;
			end
			// second cycle: pointer on the bus from Q2, enable low in Q4 only
			RD_FETCH:
			begin
				next_s.ma = s.ptr;
				if (phase == swap_tblrd_pkg::PHASE_LAST - 2'h1)
					next_s.oe_n = 1'b0;
				if (phase == swap_tblrd_pkg::PHASE_LAST)
				begin
					next_s.lat = memData;
					if (s.inc)
						next_s.ptr = s.ptr + 16'h0001;
					next_s.mode = (s.wa == swap_tblrd_pkg::PC_LOW_ADDR) ? RD_EXTRA : IDLE;
				end
			end
			// a program counter low target costs one more cycle for the refetch
			RD_EXTRA:
			begin
				if (phase == swap_tblrd_pkg::PHASE_LAST)
					next_s.mode = IDLE;
			end
		endcase
		// busy has a flop of its own so the pin never comes from a compare
		next_s.bsy = (next_s.mode != IDLE);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
			s.ptr <= swap_tblrd_pkg::POINTER_RESET;
			s.lat <= swap_tblrd_pkg::LATCH_RESET;
			s.oe_n <= 1'b1;
			s.mode <= IDLE;
		end
		else
			s <= next_s;
	end

	// outputs come straight from the state flops
	assign regWrData = s.wd;
	assign regWrAddr = s.wa;
	assign regWrEn = s.we;
	assign workWrEn = s.wwe;
	assign memAddr = s.ma;
	assign memOe_n = s.oe_n;
	assign busy = s.bsy;
	assign tablePointer = s.ptr;
	assign tableLatch = s.lat;

	// *************************
	// checks
	// *************************
	sequence s_readStart;
		isRead;
	endsequence
	// a plain read frees the block after two cycles, a program counter low read after three
	sequence s_twoCycles;
		##7 busy ##1 !busy;
	endsequence
	sequence s_threeCycles;
		##11 busy ##1 !busy;
	endsequence
	property p_swapData;
		@(posedge clk) disable iff (!reset_n) isSwap |=> regWrData == {$past(srcData[3:0]), $past(srcData[7:4])};
	endproperty
	a_swapData: assert property (p_swapData) else $error("swap data wrong");
	property p_swapDest;
		@(posedge clk) disable iff (!reset_n) isSwap |=> (regWrEn == $past(instWord[8])) && (workWrEn != regWrEn);
	endproperty
	a_swapDest: assert property (p_swapDest) else $error("swap destination wrong");
	// a swap is single cycle and never touches the memory bus
	property p_swapQuiet;
		@(posedge clk) disable iff (!reset_n) isSwap |=> !busy && memOe_n;
	endproperty
	a_swapQuiet: assert property (p_swapQuiet) else $error("swap disturbed the bus");
	property p_readBusy;
		@(posedge clk) disable iff (!reset_n) s_readStart |=> busy;
	endproperty
	a_readBusy: assert property (p_readBusy) else $error("read not decoded");
	property p_readAddr;
		@(posedge clk) disable iff (!reset_n) s_readStart |=> regWrEn && regWrAddr == $past(instWord[7:0]);
	endproperty
	a_readAddr: assert property (p_readAddr) else $error("read address wrong");
	property p_byteSel;
		@(posedge clk) disable iff (!reset_n)
			s_readStart |=> regWrData == ($past(instWord[9]) ? $past(tableLatch[15:8]) : $past(tableLatch[7:0]));
	endproperty
	a_byteSel: assert property (p_byteSel) else $error("latch byte wrong");
	property p_latchLoad;
		@(posedge clk) disable iff (!reset_n) s_readStart |-> ##8 tableLatch == $past(memData);
	endproperty
	a_latchLoad: assert property (p_latchLoad) else $error("latch not loaded");
	property p_ptrInc;
		@(posedge clk) disable iff (!reset_n)
			s_readStart |-> ##8 tablePointer == $past(tablePointer, 8) + 16'($past(instWord[8], 8));
	endproperty
	a_ptrInc: assert property (p_ptrInc) else $error("pointer step wrong");
	property p_cycles;
		@(posedge clk) disable iff (!reset_n)
			isRead && instWord[7:0] != swap_tblrd_pkg::PC_LOW_ADDR |-> s_twoCycles;
	endproperty
	a_cycles: assert property (p_cycles) else $error("read length wrong");
	property p_cyclesPcLow;
		@(posedge clk) disable iff (!reset_n)
			isRead && instWord[7:0] == swap_tblrd_pkg::PC_LOW_ADDR |-> s_threeCycles;
	endproperty
	a_cyclesPcLow: assert property (p_cyclesPcLow) else $error("long read length wrong");
	// the enable shows while the phase counter stands at its last quarter
	property p_oe;
		@(posedge clk) disable iff (!reset_n)
			!memOe_n |-> busy && memAddr == tablePointer && phase == swap_tblrd_pkg::PHASE_LAST;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable misplaced");
	// one quarter only, so the memory never sees a stretched strobe
	property p_oePulse;
		@(posedge clk) disable iff (!reset_n) !memOe_n |=> memOe_n;
	endproperty
	a_oePulse: assert property (p_oePulse) else $error("output enable too long");
endmodule
`default_nettype wire

// ### verif/prog_mem_model.sv
// program memory partner for the table read fetch
// assumes an active low output enable from the block
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model
(
	input wire logic clk,
	input wire logic [15:0] memAddr,
	input wire logic memOe_n,
	output logic [15:0] memData
);
	logic [15:0] junk = 16'h0f0f;
	// released bus wanders, so a stale word never passes for a fetch
	always @(posedge clk)
		junk <= ~junk;
	// each word is derived from its own address
	assign memData = memOe_n ? junk : (memAddr ^ 16'hc3a5);
endmodule
`default_nettype wire

// ### verif/tb.sv
// self checking bench for nibble swap and table read
// assumes the memory model answers while output enable is low
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic instValid = 1'b0;
	logic [15:0] instWord = 16'h0000;
	logic [7:0] srcData = 8'h00;
	logic [15:0] memData, memAddr, tablePointer, tableLatch;
	logic [7:0] regWrData, regWrAddr;
	logic regWrEn, workWrEn, memOe_n, busy;
	int mismatches = 0;
	int n_checks = 0;
	logic [15:0] ptr = 16'h0000;
	logic [15:0] lat = 16'h0000;
	// 200 MHz core clock, one edge per quarter
	always #2.5 clk = ~clk;
	swap_tblrd_exec i_dut (.clk(clk), .reset_n(reset_n), .instValid(instValid), .instWord(instWord),
		.srcData(srcData), .memData(memData), .regWrData(regWrData), .regWrAddr(regWrAddr),
		.regWrEn(regWrEn), .workWrEn(workWrEn), .memAddr(memAddr), .memOe_n(memOe_n), .busy(busy),
		.tablePointer(tablePointer), .tableLatch(tableLatch));
	prog_mem_model i_mem (.clk(clk), .memAddr(memAddr), .memOe_n(memOe_n), .memData(memData));
	// ****************
	// tasks
	// ****************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// present at a Q1 edge; leaves us just after that edge
	task automatic issue(input logic [15:0] w, input logic [7:0] s);
		instValid = 1'b1;
		instWord = w;
		srcData = s;
		@(posedge clk);
		#1 instValid = 1'b0;
	endtask
	task automatic swap(input logic d, input logic [7:0] a, input logic [7:0] s);
		issue({swap_tblrd_pkg::NIBBLE_SWAP_TOP, d, a}, s);
		// the write strobes stand for the one clock right after the take
		cmp(regWrData, {s[3:0], s[7:4]});
		cmp(regWrEn, d);
		cmp(workWrEn, !d);
		cmp(regWrAddr, a);
		repeat (3) @(posedge clk);
		#1;
	endtask
	// a foreign opcode must leave both write strobes and busy quiet
	task automatic bogus();
		issue(16'hffff, 8'h5a);
		cmp(regWrEn | workWrEn, 1'b0);
		cmp(busy, 1'b0);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic t, input logic i, input logic [7:0] a);
		logic pcLow;
		pcLow = (a == swap_tblrd_pkg::PC_LOW_ADDR);
		issue({swap_tblrd_pkg::TABLE_READ_TOP, t, i, a}, 8'h00);
		// the byte move shows for the one clock right after the take
		cmp(regWrEn, 1'b1);
		cmp(regWrAddr, a);
		cmp(regWrData, t ? lat[15:8] : lat[7:0]);
		cmp(busy, 1'b1);
		// Q2 of the second cycle: pointer out, enable still high
		repeat (4) @(posedge clk);
		#1;
		cmp(memAddr, ptr);
		cmp(memOe_n, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		cmp(memOe_n, 1'b0);
		@(posedge clk);
		#1;
		lat = ptr ^ 16'hc3a5;
		ptr = ptr + 16'(i);
		cmp(tableLatch, lat);
		cmp(tablePointer, ptr);
		cmp(busy, pcLow);
		cmp(memOe_n, 1'b1);
		// the longer read holds busy through one more full cycle
		if (pcLow)
		begin
			repeat ((swap_tblrd_pkg::CYCLES_PC_LOW - swap_tblrd_pkg::CYCLES_NORMAL) * 4 - 1) @(posedge clk);
			#1;
			cmp(busy, 1'b1);
			@(posedge clk);
			#1;
		end
		cmp(busy, 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// main sequence: every t and i pairing, top address and program counter low
	initial
	begin
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		cmp(tablePointer, swap_tblrd_pkg::POINTER_RESET);
		cmp(tableLatch, swap_tblrd_pkg::LATCH_RESET);
		swap(1'b0, 8'h10, 8'h53);
		swap(1'b1, 8'h11, 8'ha7);
		bogus();
		rd(1'b1, 1'b1, 8'h00);
		rd(1'b0, 1'b0, 8'hff);
		rd(1'b1, 1'b0, 8'h02);
		rd(1'b0, 1'b1, 8'h7f);
		end_of_test();
	end
	// watchdog, far beyond the 68 clocks the run needs
	initial
	begin
		#10000;
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
